// file: prg_pkg.sv
// Purpose: Shared constants and types for the pattern-unlocked serial RTC gate
// Assumes: 25 MHz system clock, 32-bit AXI4-Lite register port
// Notes:   Calendar bytes are BCD; byte i of the 64-bit image is register i

package prg_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 40;
  localparam int HUNDREDTH_NS     = 10_000_000;
  localparam int TICK_CYCLES_DFLT = HUNDREDTH_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Unlock pattern and serial sequence
  // ----------------------------------------------------------------
  // Bytes C5,3A,A3,5C,C5,3A,A3,5C from low byte up, each sent LSB first
  localparam logic [63:0] UNLOCK_PATTERN = 64'h5ca3_3ac5_5ca3_3ac5;
  localparam int          SEQ_BITS       = 64;
  localparam logic [5:0]  SEQ_LAST       = 6'h3f;

  // ----------------------------------------------------------------
  // Calendar register layout
  // ----------------------------------------------------------------
  localparam int REG_HUND  = 0;
  localparam int REG_SEC   = 1;
  localparam int REG_MIN   = 2;
  localparam int REG_HOUR  = 3;
  localparam int REG_DAY   = 4;
  localparam int REG_DATE  = 5;
  localparam int REG_MONTH = 6;
  localparam int REG_YEAR  = 7;

  localparam int HOUR_12H_BIT    = 7;
  localparam int HOUR_PM_BIT     = 5;
  localparam int DAY_RST_IGN_BIT = 4;
  localparam int DAY_OSC_OFF_BIT = 5;

  // Bits that always read zero are cleared on every load
  localparam logic [7:0][7:0] CAL_MASK =
    {8'hff, 8'h1f, 8'h3f, 8'h37, 8'hbf, 8'h7f, 8'h7f, 8'hff};
  // Oscillator stopped after reset, date 01/01/00, day 1
  localparam logic [7:0][7:0] CAL_RESET =
    {8'h00, 8'h01, 8'h01, 8'h21, 8'h00, 8'h00, 8'h00, 8'h00};

  // ----------------------------------------------------------------
  // AXI4-Lite register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_TIME_LO = 8'h08;
  localparam logic [7:0] OFS_TIME_HI = 8'h0c;

  localparam int         CTRL_LOCK_BIT = 0;
  localparam logic       CTRL_RESET    = 1'b0;
  localparam logic [1:0] RESP_OKAY     = 2'b00;
  localparam logic [1:0] RESP_SLVERR   = 2'b10;

  // STATUS field positions
  localparam int ST_STATE_LSB = 0;
  localparam int ST_MPTR_LSB  = 2;
  localparam int ST_XCNT_LSB  = 8;
  localparam int ST_PF_BIT    = 16;
  localparam int ST_ROM_BIT   = 17;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_LOCKED = 2'b00,
    ST_MATCH  = 2'b01,
    ST_XFER   = 2'b11,
    ST_REJECT = 2'b10
  } prg_state_t;

  // Asynchronous pin bundle, all sampled through two flip-flops
  typedef struct packed {
    logic sel_n;
    logic oe_n;
    logic we_n;
    logic d;
    logic rst_n;
    logic pf;
    logic rom;
  } prg_pins_t;

  localparam prg_pins_t PINS_IDLE = '{sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                      d: 1'b0, rst_n: 1'b1, pf: 1'b0,
                                      rom: 1'b0};

endpackage

// file: prg_rtc_gate.sv
// Purpose: Hidden-access RTC gate in series with a memory chip select
// Assumes: Strobes from the host are asynchronous and are synchronised here
// Notes:   Cycles are decoded on the trailing edge of the synchronised strobe

`timescale 1ns/10ps

module prg_rtc_gate
  import prg_pkg::*;
#(
  parameter int AXI_ADDR_W  = 8,
  parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite slave
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output      logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output      logic                  s_axi_wready,
  output      logic [1:0]            s_axi_bresp,
  output      logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output      logic                  s_axi_arready,
  output      logic [31:0]           s_axi_rdata,
  output      logic [1:0]            s_axi_rresp,
  output      logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Host strobes and data pins
  input  wire logic                  select_in_n,
  input  wire logic                  oe_n,
  input  wire logic                  we_n,
  input  wire logic                  d_in,
  output      logic                  q_out,
  output      logic                  q_oe,
  // Memory side
  output      logic                  memory_select_out_n,
  // Supervision pins
  input  wire logic                  transfer_reset_n,
  input  wire logic                  below_power_fail_threshold,
  input  wire logic                  rom_mode
);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  prg_pins_t pin_raw;
  prg_pins_t pin_meta;
  prg_pins_t pin_s;

  assign pin_raw = '{sel_n: select_in_n, oe_n: oe_n, we_n: we_n, d: d_in,
                     rst_n: transfer_reset_n,
                     pf: below_power_fail_threshold, rom: rom_mode};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= PINS_IDLE;
      pin_s    <= PINS_IDLE;
    end else begin
      pin_meta <= pin_raw;
      pin_s    <= pin_meta;
    end
  end

  // ------------------------------------------------------------------
  // Bus cycle decode
  // ------------------------------------------------------------------
  logic cyc_act;
  logic cyc_rd_now;
  logic cyc_wr_now;
  logic act_q;
  logic rd_seen;
  logic wr_seen;
  logic d_cap;
  logic next_act_q;
  logic next_rd_seen;
  logic next_wr_seen;
  logic next_d_cap;
  logic cyc_end;
  logic cyc_rd;
  logic cyc_wr;

  // Only selected cycles count, so unselected traffic interleaves freely
  assign cyc_rd_now = !pin_s.sel_n && !pin_s.oe_n;
  assign cyc_wr_now = !pin_s.sel_n && !pin_s.we_n;
  assign cyc_act    = cyc_rd_now || cyc_wr_now;
  assign cyc_end    = act_q && !cyc_act;
  // A write strobe wins if both were seen in one cycle
  assign cyc_wr     = cyc_end && wr_seen;
  assign cyc_rd     = cyc_end && rd_seen && !wr_seen;

  always_comb begin
    next_act_q   = cyc_act;
    next_rd_seen = cyc_act ? (rd_seen || cyc_rd_now) : 1'b0;
    next_wr_seen = cyc_act ? (wr_seen || cyc_wr_now) : 1'b0;
    // Data is taken while write strobe is low, last value wins
    next_d_cap   = cyc_wr_now ? pin_s.d : d_cap;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_q   <= 1'b0;
      rd_seen <= 1'b0;
      wr_seen <= 1'b0;
      d_cap   <= 1'b0;
    end else begin
      act_q   <= next_act_q;
      rd_seen <= next_rd_seen;
      wr_seen <= next_wr_seen;
      d_cap   <= next_d_cap;
    end
  end

  // ------------------------------------------------------------------
  // Unlock and transfer sequencer
  // ------------------------------------------------------------------
  prg_state_t       state;
  prg_state_t       next_state;
  logic [5:0]       mptr;
  logic [5:0]       next_mptr;
  logic [5:0]       xcnt;
  logic [5:0]       next_xcnt;
  logic [63:0]      shadow;
  logic [63:0]      next_shadow;
  logic             wrote;
  logic             next_wrote;
  logic             commit;
  logic             host_lock;
  logic [7:0][7:0]  cal;
  logic             abort;

  // Power fail aborts in both memory modes; reset pin only when enabled
  assign abort = pin_s.pf
               || (!pin_s.rst_n && !cal[REG_DAY][DAY_RST_IGN_BIT])
               || host_lock;

  always_comb begin
    next_state  = state;
    next_mptr   = mptr;
    next_xcnt   = xcnt;
    next_shadow = shadow;
    next_wrote  = wrote;
    commit      = 1'b0;
    if (abort) begin
      // Leave calendar untouched, drop any partial transfer
      next_state = ST_LOCKED;
      next_mptr  = 6'h00;
      next_xcnt  = 6'h00;
      next_wrote = 1'b0;
    end else begin
      case (state)
        ST_LOCKED, ST_MATCH, ST_REJECT: begin
          if (cyc_rd) begin
            next_state = ST_MATCH;
            next_mptr  = 6'h00;
          end else if (cyc_wr && state == ST_MATCH) begin
            if (d_cap == UNLOCK_PATTERN[mptr]) begin
              next_mptr = mptr + 6'h01;
              if (mptr == SEQ_LAST) begin
                next_state  = ST_XFER;
                next_xcnt   = 6'h00;
                next_shadow = cal;
                next_wrote  = 1'b0;
              end
            end else begin
              next_state = ST_REJECT;
            end
          end
        end
        ST_XFER: begin
          if (cyc_rd || cyc_wr) begin
            if (cyc_wr) begin
              next_shadow[xcnt] = d_cap;
              next_wrote        = 1'b1;
            end
            next_xcnt = xcnt + 6'h01;
            if (xcnt == SEQ_LAST) begin
              next_state = ST_LOCKED;
              next_mptr  = 6'h00;
              commit     = next_wrote;
            end
          end
        end
        default: begin
          next_state = ST_LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state  <= ST_LOCKED;
      mptr   <= 6'h00;
      xcnt   <= 6'h00;
      shadow <= 64'h0;
      wrote  <= 1'b0;
    end else begin
      state  <= next_state;
      mptr   <= next_mptr;
      xcnt   <= next_xcnt;
      shadow <= next_shadow;
      wrote  <= next_wrote;
    end
  end

  // ------------------------------------------------------------------
  // Pin outputs
  // ------------------------------------------------------------------
  logic next_msel_n;
  logic next_q_out;
  logic next_q_oe;

  always_comb begin
    if (pin_s.pf) begin
      next_msel_n = pin_s.rom ? 1'b0 : 1'b1;
    end else if (state == ST_XFER) begin
      next_msel_n = 1'b1;
    end else begin
      next_msel_n = pin_s.sel_n;
    end
    next_q_out = shadow[xcnt];
    next_q_oe  = (state == ST_XFER) && cyc_rd_now && !abort;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      memory_select_out_n <= 1'b1;
      q_out               <= 1'b0;
      q_oe                <= 1'b0;
    end else begin
      memory_select_out_n <= next_msel_n;
      q_out               <= next_q_out;
      q_oe                <= next_q_oe;
    end
  end

  // ------------------------------------------------------------------
  // Calendar
  // ------------------------------------------------------------------
  logic [31:0]     tick_cnt;
  logic [31:0]     next_tick_cnt;
  logic            tick;
  logic [7:0][7:0] next_cal;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v,
                                         input logic [7:0] vmax,
                                         input logic [7:0] vmin);
    logic [7:0] r;
    r = 8'h00;
    if (v >= vmax) begin
      r = vmin;
    end else if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = v + 8'h01;
    end
    return r;
  endfunction

  // BCD year within one century ending at 2099
  function automatic logic is_leap(input logic [7:0] y);
    logic r;
    r = 1'b0;
    if (y[4]) begin
      r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
    return r;
  endfunction

  function automatic logic [7:0] month_len(input logic [7:0] m,
                                           input logic [7:0] y);
    logic [7:0] r;
    r = 8'h31;
    case (m)
      8'h02:                      r = is_leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
      default:                    r = 8'h31;
    endcase
    return r;
  endfunction

  assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

  always_comb begin
    logic       carry;
    logic [7:0] hr;
    logic [7:0] ml;
    logic [7:0] hn;
    carry         = 1'b0;
    hr            = 8'h00;
    hn            = 8'h00;
    ml            = month_len(cal[REG_MONTH], cal[REG_YEAR]);
    next_cal      = cal;
    next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
    if (commit) begin
      for (int i = 0; i < 8; i++) begin
        next_cal[i] = shadow[8*i +: 8] & CAL_MASK[i];
      end
      next_cal[REG_YEAR][7] = next_shadow[SEQ_BITS-1];
    end else if (tick && !cal[REG_DAY][DAY_OSC_OFF_BIT]) begin
      next_cal[REG_HUND] = bcd_inc(cal[REG_HUND], 8'h99, 8'h00);
      carry = (cal[REG_HUND] == 8'h99);
      if (carry) begin
        next_cal[REG_SEC] = bcd_inc(cal[REG_SEC], 8'h59, 8'h00);
        carry = (cal[REG_SEC] == 8'h59);
      end
      if (carry) begin
        next_cal[REG_MIN] = bcd_inc(cal[REG_MIN], 8'h59, 8'h00);
        carry = (cal[REG_MIN] == 8'h59);
      end
      if (carry) begin
        if (cal[REG_HOUR][HOUR_12H_BIT]) begin
          hr = {3'b000, cal[REG_HOUR][4:0]};
          carry = 1'b0;
          if (hr == 8'h12) begin
            next_cal[REG_HOUR][4:0] = 5'h01;
          end else if (hr == 8'h11) begin
            next_cal[REG_HOUR][4:0] = 5'h12;
            next_cal[REG_HOUR][HOUR_PM_BIT] = !cal[REG_HOUR][HOUR_PM_BIT];
            carry = cal[REG_HOUR][HOUR_PM_BIT];
          end else begin
            hn = bcd_inc(hr, 8'h12, 8'h01);
            next_cal[REG_HOUR][4:0] = hn[4:0];
          end
        end else begin
          hr = {2'b00, cal[REG_HOUR][5:0]};
          hn = bcd_inc(hr, 8'h23, 8'h00);
          next_cal[REG_HOUR][5:0] = hn[5:0];
          carry = (hr == 8'h23);
        end
      end
      if (carry) begin
        next_cal[REG_DAY][2:0] = (cal[REG_DAY][2:0] == 3'h7) ? 3'h1
                               : cal[REG_DAY][2:0] + 3'h1;
        next_cal[REG_DATE] = bcd_inc(cal[REG_DATE], ml, 8'h01);
        carry = (cal[REG_DATE] >= ml);
      end
      if (carry) begin
        next_cal[REG_MONTH] = bcd_inc(cal[REG_MONTH], 8'h12, 8'h01);
        carry = (cal[REG_MONTH] == 8'h12);
      end
      if (carry) begin
        next_cal[REG_YEAR] = bcd_inc(cal[REG_YEAR], 8'h99, 8'h00);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal      <= CAL_RESET;
      tick_cnt <= 32'h0;
    end else begin
      cal      <= next_cal;
      tick_cnt <= next_tick_cnt;
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------------
  logic [7:0]  aw_addr;
  logic        aw_full;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_full;
  logic [7:0]  next_aw_addr;
  logic        next_aw_full;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_w_full;
  logic        next_awready;
  logic        next_wready;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_arready;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        next_host_lock;
  logic [7:0]  ar_ofs;
  logic [31:0] status_word;

  assign ar_ofs = 8'(s_axi_araddr);

  always_comb begin
    status_word = 32'h0;
    status_word[ST_STATE_LSB +: 2] = state;
    status_word[ST_MPTR_LSB +: 6]  = mptr;
    status_word[ST_XCNT_LSB +: 6]  = xcnt;
    status_word[ST_PF_BIT]         = pin_s.pf;
    status_word[ST_ROM_BIT]        = pin_s.rom;
  end

  always_comb begin
    next_aw_addr   = aw_addr;
    next_aw_full   = aw_full;
    next_w_data    = w_data;
    next_w_strb    = w_strb;
    next_w_full    = w_full;
    next_bvalid    = s_axi_bvalid;
    next_bresp     = s_axi_bresp;
    next_host_lock = host_lock;
    // Ready again whenever no read answer is pending, reset included
    next_arready   = s_axi_arready || !s_axi_rvalid;
    next_rvalid    = s_axi_rvalid;
    next_rdata     = s_axi_rdata;
    next_rresp     = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_addr = 8'(s_axi_awaddr);
      next_aw_full = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
      next_w_full = 1'b1;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_full && w_full && !s_axi_bvalid) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      case ({aw_addr[7:2], 2'b00})
        OFS_CTRL: begin
          if (w_strb[0]) begin
            next_host_lock = w_data[CTRL_LOCK_BIT];
          end
        end
        OFS_STATUS, OFS_TIME_LO, OFS_TIME_HI: begin
          next_bresp = RESP_OKAY;
        end
        default: begin
          next_bresp = RESP_SLVERR;
        end
      endcase
    end
    next_awready = !next_aw_full && !next_bvalid;
    next_wready  = !next_w_full && !next_bvalid;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = RESP_OKAY;
      case ({ar_ofs[7:2], 2'b00})
        OFS_CTRL:    next_rdata = {31'h0, host_lock};
        OFS_STATUS:  next_rdata = status_word;
        OFS_TIME_LO: next_rdata = cal[3:0];
        OFS_TIME_HI: next_rdata = cal[7:4];
        default: begin
          next_rdata = 32'h0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr       <= 8'h00;
      aw_full       <= 1'b0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      w_full        <= 1'b0;
      host_lock     <= CTRL_RESET;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      aw_addr       <= next_aw_addr;
      aw_full       <= next_aw_full;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      w_full        <= next_w_full;
      host_lock     <= next_host_lock;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

endmodule // prg_rtc_gate

// file: prg_chk_asserts.sv
// Purpose: Port checks on the RTC gate
// Assumes: One clock domain
// Notes:   Bound to every gate instance
`timescale 1ns/10ps
module prg_chk
  import prg_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Gate pins
  input wire logic select_in_n,
  input wire logic q_oe,
  input wire logic memory_select_out_n,
  input wire logic below_power_fail_threshold,
  input wire logic rom_mode
);
  wire pf = below_power_fail_threshold;
  wire mem_n = memory_select_out_n;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Five cycles cover two sync flops plus the output flop
  a_pf_ram_high: assert property (
    (pf && !rom_mode) [*5] |-> mem_n) else $error("ram pf sel low");
  a_pf_rom_low: assert property (
    (pf && rom_mode) [*5] |-> !mem_n) else $error("rom pf sel high");
  a_idle_track: assert property (
    (!pf && select_in_n) [*5] |-> mem_n) else $error("sel not kept");
  a_xfer_desel: assert property (
    $rose(q_oe) |-> mem_n) else $error("memory on in read");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready
    |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
    |-> ##[1:2] s_axi_rvalid) else $error("read answer late");
  a_aw_busy: assert property (s_axi_awvalid && s_axi_awready
    |=> !s_axi_awready) else $error("address taken twice");
  a_ar_busy: assert property (s_axi_arvalid && s_axi_arready
    |=> !s_axi_arready) else $error("read taken twice");
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_bit_read: cover property ($rose(q_oe));
  c_rom_pf: cover property (pf && rom_mode && !mem_n);
endmodule // prg_chk

bind prg_rtc_gate prg_chk prg_chk_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .select_in_n, .q_oe,
  .memory_select_out_n, .below_power_fail_threshold, .rom_mode);

// file: prg_host.sv
// Purpose: Host strobe model facing the gate
// Assumes: Strobes well over the three-cycle sync floor
// Notes:   q and m hold the last sampled answers
`timescale 1ns/10ps
module prg_host
  import prg_pkg::*;
(
  input  wire logic aclk,
  output      logic select_in_n,
  output      logic oe_n,
  output      logic we_n,
  output      logic d_in,
  input  wire logic q_out,
  input  wire logic memory_select_out_n
);
  logic q, m;
  initial {select_in_n, oe_n, we_n, d_in} = 4'he;
  task automatic cyc(input logic s, w, b);
    @(posedge aclk);
    select_in_n <= s;
    oe_n <= w;
    we_n <= !w;
    d_in <= b;
    repeat (5) @(posedge aclk);
    q = q_out;
    m = memory_select_out_n;
    {select_in_n, oe_n, we_n} <= 3'h7;
    d_in <= !b; // Released line must not keep a stale bit
    repeat (5) @(posedge aclk);
  endtask
  // Bit bad goes out inverted; 64 sends the clean pattern
  task automatic unlock(input int bad);
    cyc(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < SEQ_BITS; i++) begin
      if (i == 20) cyc(1'b1, 1'b0, 1'b0);
      cyc(1'b0, 1'b1, UNLOCK_PATTERN[i] ^ (i == bad));
    end
  endtask
endmodule // prg_host

// file: prg_rtc_gate_tb.sv
// Purpose: Self-checking bench for the RTC gate
// Assumes: Hundredth tick cut to 4 cycles
// Notes:   Channels bready and rready stay high
`timescale 1ns/10ps
module prg_rtc_gate_tb
  import prg_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, oe_n;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, select_in_n, q_oe;
  logic we_n, d_in, q_out, memory_select_out_n, transfer_reset_n;
  logic below_power_fail_threshold, rom_mode;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [63:0] img;
  int err_count, n_tests, cyc_n;
  prg_rtc_gate #(.TICK_CYCLES(4)) prg_rtc_gate_i (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .select_in_n, .oe_n, .we_n, .d_in, .q_out, .q_oe,
    .memory_select_out_n, .transfer_reset_n,
    .below_power_fail_threshold, .rom_mode);
  prg_host prg_host_i (.aclk, .select_in_n, .oe_n, .we_n, .d_in,
    .q_out, .memory_select_out_n);
  task automatic chk(input logic [63:0] g, e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %0h want %0h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [1:0] e);
    s_axi_awaddr <= a;
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk(64'(s_axi_bresp), 64'(e));
  endtask
  task automatic axr(input logic [7:0] a, input logic [1:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    chk(64'(s_axi_rresp), 64'(e));
  endtask
  task automatic st(input logic [7:0] e, m);
    axr(OFS_STATUS, RESP_OKAY);
    chk(64'(rd[7:0] & m), 64'(e));
  endtask
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Ceiling sits well above the roughly 5200 cycles the run needs
  always @(posedge aclk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {below_power_fail_threshold, rom_mode, s_axi_wdata} = '0;
    {s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_bready, s_axi_rready, transfer_reset_n} = 3'h7;
    s_axi_wstrb = 4'hf;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    axw(8'h10, RESP_SLVERR);
    axr(8'h10, RESP_SLVERR);
    chk(64'(rd), 64'h0);
    s_axi_wdata <= 32'h1;
    axw(OFS_CTRL, RESP_OKAY);
    prg_host_i.cyc(1'b0, 1'b0, 1'b0);
    st(8'h00, 8'hff);
    {s_axi_wdata, s_axi_wstrb} <= 36'h0;
    axw(OFS_CTRL, RESP_OKAY);
    axr(OFS_CTRL, RESP_OKAY);
    chk(64'(rd), 64'h1);
    s_axi_wstrb <= 4'hf;
    axw(OFS_CTRL, RESP_OKAY);
    axr(OFS_CTRL, RESP_OKAY);
    chk(64'(rd), 64'h0);
    $display("regs done");
    prg_host_i.unlock(10);
    st(8'h2a, 8'hff);
    prg_host_i.cyc(1'b0, 1'b0, 1'b0);
    chk(64'(prg_host_i.m), 64'h0);
    for (int i = 0; i < 5; i++)
      prg_host_i.cyc(1'b0, 1'b1, UNLOCK_PATTERN[i]);
    st(8'h15, 8'hff);
    prg_host_i.cyc(1'b0, 1'b0, 1'b0);
    st(8'h01, 8'hff);
    $display("match done");
    prg_host_i.unlock(64);
    st(8'h03, 8'h03);
    for (int i = 0; i < 64; i++) begin
      prg_host_i.cyc(1'b0, 1'b0, 1'b0);
      img[i] = prg_host_i.q;
      chk(64'(prg_host_i.m), 64'h1);
    end
    chk(img, CAL_RESET);
    st(8'h00, 8'h03);
    img = 64'h0002_2801_2359_5999;
    prg_host_i.unlock(64);
    for (int i = 0; i < 64; i++) prg_host_i.cyc(1'b0, 1'b1, img[i]);
    repeat (8) @(posedge aclk);
    axr(OFS_TIME_HI, RESP_OKAY);
    chk(64'(rd), 64'h0002_2902);
    axr(OFS_TIME_LO, RESP_OKAY);
    chk(64'(rd[31:8]), 64'h0);
    $display("calendar done");
    prg_host_i.unlock(64);
    below_power_fail_threshold <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(64'(memory_select_out_n), 64'h1);
    rom_mode <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(64'(memory_select_out_n), 64'h0);
    axr(OFS_STATUS, RESP_OKAY);
    chk(64'({rd[17:16], rd[1:0]}), 64'hc);
    {below_power_fail_threshold, rom_mode} <= 2'h0;
    prg_host_i.unlock(64);
    transfer_reset_n <= 1'b0;
    repeat (6) @(posedge aclk);
    st(8'h00, 8'h03);
    $display("supervision done");
    print_verdict();
  end
endmodule // prg_rtc_gate_tb
